//--- verilog/mrtc_top.sv
`timescale 1ns/1ps
module mrtc_top #(
   parameter int PULSE_CYCLES = mrtc_pkg::PULSE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic mains_clock_input,
   output logic alarm_interrupt_n_o,
   output logic alarm_interrupt_n_oe_n
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] to_bcd(input logic [6:0] v);
      logic [6:0] t;
      logic [6:0] u;
      t = v / 7'd10;
      u = v % 7'd10;
      return {t[3:0], u[3:0]};
   endfunction

   function automatic logic [6:0] from_bcd(input logic [7:0] b);
      return 7'(7'(b[7:4]) * 7'd10 + 7'(b[3:0]));
   endfunction

   function automatic logic [4:0] month_len(input logic [3:0] m, input logic leap);
      logic [4:0] n;
      n = 5'd31;
      if (m == 4'd4 || m == 4'd6 || m == 4'd9 || m == 4'd11) begin
         n = 5'd30;
      end else if (m == 4'd2) begin
         n = leap ? 5'd29 : 5'd28;
      end
      return n;
   endfunction

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [7:0] ctl_q;
   logic [7:0] mains_q;
   logic [7:0] snap_q [0:7];
   logic [7:0] alm_q [0:11];
   logic [7:0] ram_q [0:mrtc_pkg::RAM_BYTES-1];
   logic [1:0] flag_q;
   logic pf_q;

   wire [7:0] idx = paddr[9:2];
   wire is_rtc = idx <= mrtc_pkg::IDX_SUBSEC;
   wire is_sr = idx == mrtc_pkg::IDX_STATUS;
   wire is_int = idx == mrtc_pkg::IDX_INT;
   wire is_mains = idx == mrtc_pkg::IDX_MAINS;
   wire is_dst = idx >= mrtc_pkg::IDX_DST_LO && idx <= mrtc_pkg::IDX_DST_HI;
   wire is_alm = idx >= mrtc_pkg::IDX_ALM_LO && idx <= mrtc_pkg::IDX_ALM_HI;
   wire is_ram = idx >= mrtc_pkg::IDX_RAM_LO;
   wire mapped = is_rtc | is_sr | is_int | is_mains | is_dst | is_alm | is_ram;
   wire [7:0] alm_off = idx - mrtc_pkg::IDX_ALM_LO;
   wire setup = psel & ~penable;
   wire wr_fire = psel & penable & pready_q & pwrite;
   wire rd_fire = psel & penable & pready_q & ~pwrite;
   wire unlock = ctl_q[mrtc_pkg::BIT_CLOCK_WRITE_UNLOCK];
   wire pulsed = ctl_q[mrtc_pkg::BIT_IM];
   wire auto_clear_on_read = ctl_q[mrtc_pkg::BIT_AUTO_CLEAR_ON_READ];
   wire [1:0] ale = ctl_q[1:0];
   wire hz60 = mains_q[mrtc_pkg::BIT_HZ60];
   wire rtc_wr = wr_fire & is_rtc & unlock;
   wire sr_wr = wr_fire & is_sr;
   wire sr_rd = rd_fire & is_sr;
   wire [7:0] sr_val = {2'b00, flag_q, 3'b000, pf_q};
   wire [7:0] rd_val = is_rtc ? snap_q[idx[2:0]] :
                       is_sr ? sr_val :
                       is_int ? ctl_q :
                       is_mains ? mains_q :
                       is_alm ? alm_q[alm_off[3:0]] :
                       is_ram ? ram_q[idx[6:0]] : 8'h00;

   // ------------------------------------------------------------
   // Bus slave, one wait state
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         if (psel & penable & ~pready_q) begin
            prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
            pslverr_q <= ~mapped;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (wr_fire & is_ram) begin
         ram_q[idx[6:0]] <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // Mains timebase
   // ------------------------------------------------------------
   logic ac_s1_q;
   logic ac_s2_q;
   logic ac_s3_q;
   logic [2:0] cyc_q;
   logic tick_q;
   wire ac_edge = ac_s2_q & ~ac_s3_q;
   wire [2:0] div = hz60 ? mrtc_pkg::DIV_60HZ : mrtc_pkg::DIV_50HZ;
   wire cyc_end = cyc_q >= div - 3'd1;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ac_s1_q <= 1'b0;
         ac_s2_q <= 1'b0;
         ac_s3_q <= 1'b0;
         cyc_q <= 3'h0;
         tick_q <= 1'b0;
      end else begin
         ac_s1_q <= mains_clock_input;
         ac_s2_q <= ac_s1_q;
         ac_s3_q <= ac_s2_q;
         tick_q <= ac_edge & cyc_end;
         if (rtc_wr) begin
            cyc_q <= 3'h0;
         end else if (ac_edge) begin
            cyc_q <= cyc_end ? 3'h0 : cyc_q + 3'd1;
         end
      end
   end

   // ------------------------------------------------------------
   // Time counters (binary inside, BCD at the registers)
   // ------------------------------------------------------------
   logic run_q;
   logic [3:0] tenth_q;
   logic [5:0] sec_q;
   logic [5:0] min_q;
   logic [4:0] hour_q;
   logic [4:0] date_q;
   logic [3:0] month_q;
   logic [6:0] year_q;
   logic [2:0] dow_q;
   logic fmt24_q;

   wire leap = year_q[1:0] == 2'b00;
   wire [4:0] dim = month_len(month_q, leap);
   wire c_ten = tick_q & run_q & tenth_q == 4'd9;
   wire c_sec = c_ten & sec_q == 6'd59;
   wire c_min = c_sec & min_q == 6'd59;
   wire c_hr = c_min & hour_q == 5'd23;
   wire c_day = c_hr & date_q == dim;
   wire c_mon = c_day & month_q == 4'd12;
   wire [6:0] wr_bin = from_bcd(pwdata[7:0]);
   wire [6:0] w12 = from_bcd({3'b000, pwdata[4:0]});
   wire [6:0] w12h = (w12 == 7'd12) ? 7'd0 : w12;
   wire [6:0] w12p = w12h + (pwdata[mrtc_pkg::BIT_PM] ? 7'd12 : 7'd0);
   wire [6:0] hr_w = pwdata[7] ? from_bcd({2'b00, pwdata[5:0]}) : w12p;
   wire [4:0] h12 = (hour_q == 5'd0) ? 5'd12 : (hour_q > 5'd12) ? hour_q - 5'd12 : hour_q;
   wire [7:0] h12_b = to_bcd({2'b00, h12});
   wire [7:0] h24_b = to_bcd({2'b00, hour_q});
   wire [7:0] hr_reg = fmt24_q ? {2'b10, h24_b[5:0]} :
                       {2'b00, hour_q >= 5'd12, h12_b[4:0]};
   wire [7:0] cur [0:7];
   assign cur[0] = to_bcd({1'b0, sec_q});
   assign cur[1] = to_bcd({1'b0, min_q});
   assign cur[2] = hr_reg;
   assign cur[3] = to_bcd({2'b00, date_q});
   assign cur[4] = to_bcd({3'b000, month_q});
   assign cur[5] = to_bcd(year_q);
   assign cur[6] = {5'h00, dow_q};
   assign cur[7] = {4'h0, tenth_q};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_q <= 1'b0;
         tenth_q <= 4'h0;
         sec_q <= 6'h00;
         min_q <= 6'h00;
         hour_q <= 5'h00;
         date_q <= 5'h01;
         month_q <= 4'h1;
         year_q <= 7'h00;
         dow_q <= 3'h0;
         fmt24_q <= 1'b0;
      end else if (rtc_wr) begin
         run_q <= 1'b1;
         tenth_q <= 4'h0;
         case (idx[2:0])
            3'd0: sec_q <= wr_bin[5:0];
            3'd1: min_q <= wr_bin[5:0];
            3'd2: begin
               hour_q <= hr_w[4:0];
               fmt24_q <= pwdata[mrtc_pkg::BIT_FMT24];
            end
            3'd3: date_q <= wr_bin[4:0];
            3'd4: month_q <= wr_bin[3:0];
            3'd5: year_q <= wr_bin;
            3'd6: dow_q <= pwdata[2:0];
            default: tenth_q <= 4'h0;
         endcase
      end else if (tick_q & run_q) begin
         tenth_q <= (tenth_q == 4'd9) ? 4'h0 : tenth_q + 4'd1;
         if (c_ten) begin
            sec_q <= (sec_q == 6'd59) ? 6'h00 : sec_q + 6'd1;
         end
         if (c_sec) begin
            min_q <= (min_q == 6'd59) ? 6'h00 : min_q + 6'd1;
         end
         if (c_min) begin
            hour_q <= (hour_q == 5'd23) ? 5'h00 : hour_q + 5'd1;
         end
         if (c_hr) begin
            date_q <= c_day ? 5'h01 : date_q + 5'd1;
            dow_q <= (dow_q == 3'd6) ? 3'h0 : dow_q + 3'd1;
         end
         if (c_day) begin
            month_q <= c_mon ? 4'h1 : month_q + 4'd1;
         end
         if (c_mon) begin
            year_q <= (year_q == 7'd99) ? 7'h00 : year_q + 7'd1;
         end
      end
   end

   // ------------------------------------------------------------
   // Read snapshot and control registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            snap_q[i] <= 8'h00;
         end
         ctl_q <= mrtc_pkg::RST_INT;
         mains_q <= mrtc_pkg::RST_MAINS;
      end else begin
         if (setup & ~pwrite & (is_rtc | is_alm)) begin
            for (int i = 0; i < 8; i++) begin
               snap_q[i] <= cur[i];
            end
         end
         if (wr_fire & is_int) begin
            ctl_q <= {pwdata[7:5], 3'b000, pwdata[1:0]};
         end
         if (wr_fire & is_mains) begin
            mains_q <= {pwdata[7:6], 6'h00};
         end
      end
   end

   // ------------------------------------------------------------
   // Alarms
   // ------------------------------------------------------------
   logic [1:0] match_prev_q;
   logic [1:0] rise;
   logic [31:0] pulse_q;
   logic irq_n_q;

   for (genvar g = 0; g < 2; g++) begin : g_alm
      logic [5:0] hit;
      logic [5:0] en;
      for (genvar k = 0; k < mrtc_pkg::ALM_FIELDS; k++) begin : g_fld
         localparam int C = (k == 5) ? 6 : k;
         assign en[k] = alm_q[g * 6 + k][7];
         assign hit[k] = ~en[k] | (alm_q[g * 6 + k][6:0] == cur[C][6:0]);
      end
      wire match = (&hit) & (|en) & run_q;
      assign rise[g] = match & ~match_prev_q[g];
      wire clr = (sr_wr & ~pwdata[mrtc_pkg::BIT_ALARM0_FLAG + g]) | (sr_rd & auto_clear_on_read);

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            match_prev_q[g] <= 1'b0;
            flag_q[g] <= 1'b0;
            for (int k = 0; k < mrtc_pkg::ALM_FIELDS; k++) begin
               alm_q[g * 6 + k] <= (k == 3 || k == 4) ? mrtc_pkg::RST_ALM_DATE :
                                   mrtc_pkg::RST_ALM_OTHER;
            end
         end else begin
            match_prev_q[g] <= match;
            flag_q[g] <= rise[g] | (flag_q[g] & ~clr);
            for (int k = 0; k < mrtc_pkg::ALM_FIELDS; k++) begin
               if (wr_fire & is_alm & alm_off[3:0] == 4'(g * 6 + k)) begin
                  alm_q[g * 6 + k] <= pwdata[7:0];
               end
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pf_q <= 1'b1;
         pulse_q <= 32'h0000_0000;
         irq_n_q <= 1'b1;
      end else begin
         if (sr_wr & ~pwdata[mrtc_pkg::BIT_PF]) begin
            pf_q <= 1'b0;
         end
         if (pulsed & |(rise & ale)) begin
            pulse_q <= 32'(PULSE_CYCLES);
         end else if (pulse_q != 32'h0000_0000) begin
            pulse_q <= pulse_q - 32'd1;
         end
         irq_n_q <= pulsed ? pulse_q == 32'h0000_0000 : ~|(flag_q & ale);
      end
   end

   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign alarm_interrupt_n_o = 1'b0;
   assign alarm_interrupt_n_oe_n = irq_n_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   bus_wait_a: assert property (@(posedge clk) disable iff (rst)
      psel & penable & ~pready_q |=> pready_q ##1 ~pready_q)
      else $error("bus answer not one wait state");
   freeze_a: assert property (@(posedge clk) disable iff (rst)
      ~run_q & ~rtc_wr |=> $stable(tenth_q) & $stable(sec_q))
      else $error("clock counted before first write");
   pf_clear_a: assert property (@(posedge clk) disable iff (rst)
      $fell(pf_q) |-> $past(sr_wr) & ~$past(pwdata[0]))
      else $error("power fail flag cleared without write");
   subsec_clr_a: assert property (@(posedge clk) disable iff (rst)
      rtc_wr |=> tenth_q == 4'h0)
      else $error("subsecond not cleared on clock write");
   locked_wr_a: assert property (@(posedge clk) disable iff (rst)
      wr_fire & is_rtc & ~unlock & ~(tick_q & run_q) |=> $stable(sec_q) & $stable(min_q))
      else $error("locked clock write took effect");
   flag_set_a: assert property (@(posedge clk) disable iff (rst)
      rise[0] |=> flag_q[0])
      else $error("alarm flag not set on match");
   single_irq_a: assert property (@(posedge clk) disable iff (rst)
      ~pulsed & flag_q[0] & ale[0] |=> ~irq_n_q)
      else $error("single mode irq not asserted");
   pulse_len_a: assert property (@(posedge clk) disable iff (rst)
      pulsed & rise[0] & ale[0] |=> pulse_q == 32'(PULSE_CYCLES) ##1 ~irq_n_q)
      else $error("pulse not started");
   auto_clr_a: assert property (@(posedge clk) disable iff (rst)
      sr_rd & auto_clear_on_read & ~rise[0] |=> ~flag_q[0])
      else $error("auto clear on read failed");
   date_roll_a: assert property (@(posedge clk) disable iff (rst)
      c_day & ~rtc_wr |=> date_q == 5'h01)
      else $error("date did not roll to first");
   tenth_step_a: assert property (@(posedge clk) disable iff (rst)
      tick_q & run_q & ~rtc_wr & tenth_q != 4'd9 |=> tenth_q == $past(tenth_q) + 4'd1)
      else $error("tenths did not advance on tick");
   flag_clr_a: assert property (@(posedge clk) disable iff (rst)
      sr_wr & ~pwdata[mrtc_pkg::BIT_ALARM0_FLAG] & ~rise[0] |=> ~flag_q[0])
      else $error("alarm flag not cleared by write");
   snap_take_a: assert property (@(posedge clk) disable iff (rst)
      setup & ~pwrite & is_rtc |=> snap_q[0] == $past(cur[0]))
      else $error("read snapshot not taken");
   fmt_sel_a: assert property (@(posedge clk) disable iff (rst)
      rtc_wr & idx[2:0] == 3'd2 |=> fmt24_q == $past(pwdata[mrtc_pkg::BIT_FMT24]))
      else $error("hour format bit not stored");
   bus_err_a: assert property (@(posedge clk) disable iff (rst)
      psel & penable & ~pready_q & ~mapped |=> pslverr_q)
      else $error("unmapped access not flagged");
endmodule

//--- verilog/mrtc_pkg.sv
// Summary of operation
// - Whole timebase comes from the synchronised mains input, 50 or 60 Hz.
// - Counts tenths, seconds, minutes, hours, weekday, date, month and year.
// - Date rolls over per month length; February gets leap-year correction.
// - hour_format_24 selects 24-hour form or 12-hour form with PM bit.
// - After power-up the counters stay frozen until a clock register is written with the unlock bit set.
// - power_fail_flag is set at power-up after total supply loss.
// - Leap-year handling stays correct for every year through the limit year.
// - Two alarms take any time value; match status is readable from status_register.
// - An alarm field takes part in the match only when its MSB is set.
// - irq_mode_select clear gives single-event mode, set gives pulsed mode.
// - Single-event match drives alarm_interrupt_n low and sets the alarm flag.
// - Host clears an alarm flag by writing zero to its bit.
// - With auto_clear_on_read set, reading status_register clears alarm flags.
// - Pulsed alarm stays armed and pulses again on every later match.
// - Pulse recurrence follows the highest enabled alarm field.
// - Each pulsed match holds alarm_interrupt_n low 250 ms and sets the flag.
// - alarm_interrupt_n is an open-drain active-low output to the host.
// - Host access path is a bidirectional bus slave for register transfers.
// - A 128-byte user SRAM is readable and writable by the host.
// - Time registers read and write in BCD within their natural ranges.
// - subsecond_count is read-only and clears on any timekeeping write made with the unlock bit set.
// - A read of clock or alarm registers snapshots the time first.
package mrtc_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_SEC = 8'h00;
   localparam logic [7:0] IDX_MIN = 8'h01;
   localparam logic [7:0] IDX_HOUR = 8'h02;
   localparam logic [7:0] IDX_DATE = 8'h03;
   localparam logic [7:0] IDX_MONTH = 8'h04;
   localparam logic [7:0] IDX_YEAR = 8'h05;
   localparam logic [7:0] IDX_DOW = 8'h06;
   localparam logic [7:0] IDX_SUBSEC = 8'h07;
   localparam logic [7:0] IDX_STATUS = 8'h08;
   localparam logic [7:0] IDX_INT = 8'h0C;
   localparam logic [7:0] IDX_MAINS = 8'h13;
   localparam logic [7:0] IDX_DST_LO = 8'h15;
   localparam logic [7:0] IDX_DST_HI = 8'h1C;
   localparam logic [7:0] IDX_ALM_LO = 8'h1D;
   localparam logic [7:0] IDX_ALM_HI = 8'h28;
   localparam logic [7:0] IDX_RAM_LO = 8'h80;
   localparam int RAM_BYTES = 128;
   localparam int ALM_FIELDS = 6;
   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int BIT_PF = 0;
   localparam int BIT_ALARM0_FLAG = 4;
   localparam int BIT_AUTO_CLEAR_ON_READ = 7;
   localparam int BIT_CLOCK_WRITE_UNLOCK = 6;
   localparam int BIT_IM = 5;
   localparam int BIT_FMT24 = 7;
   localparam int BIT_PM = 5;
   localparam int BIT_HZ60 = 7;
   localparam int BIT_AC_EN = 6;
   localparam logic [7:0] RST_INT = 8'h01;
   localparam logic [7:0] RST_MAINS = 8'h00;
   localparam logic [7:0] RST_ALM_DATE = 8'h01;
   localparam logic [7:0] RST_ALM_OTHER = 8'h00;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_KHZ = 250_000;
   localparam int PULSE_MS = 250;
   localparam int PULSE_CYC = PULSE_MS * CLK_KHZ;
   localparam logic [2:0] DIV_50HZ = 3'h5;
   localparam logic [2:0] DIV_60HZ = 3'h6;
endpackage

//--- bench/mrtc_host_model.sv
`timescale 1ns/1ps
// ----
// Host bus master, mains source and interrupt pull-up
// ----
module mrtc_host_model (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [9:0] paddr,
   output logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output logic mains_clock_input,
   input wire logic alarm_interrupt_n_o,
   input wire logic alarm_interrupt_n_oe_n,
   output logic irq_line
);
   // Pulled up unless the device sinks it
   assign irq_line = alarm_interrupt_n_oe_n ? 1'b1 : alarm_interrupt_n_o;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0000_0000;
      mains_clock_input = 1'b0;
      #13;
      forever #40 mains_clock_input = ~mains_clock_input;
   end
   // One transfer; the host waits for the device's pready to end every access
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       output logic [32:0] rsp);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rsp = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
   endtask
endmodule

//--- bench/mains_timed_rtc_with_alarms_tb.sv
`timescale 1ns/1ps
module mains_timed_rtc_with_alarms_tb;
   localparam int PULSE = 20;
   logic clk;
   logic rst;
   logic psel, penable, pwrite, pready, pslverr, mains, irq_o, irq_oe_n, irq_line;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [32:0] rsp;
   logic [7:0] a, d;
   int error_cnt = 0;
   int checked = 0;
   int n;

   mrtc_top #(.PULSE_CYCLES(PULSE)) DUT (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .mains_clock_input(mains),
      .alarm_interrupt_n_o(irq_o), .alarm_interrupt_n_oe_n(irq_oe_n));
   mrtc_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .mains_clock_input(mains), .alarm_interrupt_n_o(irq_o),
      .alarm_interrupt_n_oe_n(irq_oe_n), .irq_line(irq_line));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ----
   // Helpers
   // ----
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      host.xfer(1'b1, idx, v, rsp);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
      host.xfer(1'b0, idx, 8'h00, rsp);
      chk(rsp, {25'h0, e});
   endtask
   task automatic wait_irq(input logic lvl);
      n = 0;
      while (irq_line !== lvl && n < 4000) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic edges(input int k);
      repeat (k * 20) @(posedge clk);
   endtask
   function automatic int b2i(logic [7:0] b);
      return b[7:4] * 10 + b[3:0];
   endfunction
   function automatic logic [7:0] i2b(int i);
      return 8'((i / 10) * 16 + i % 10);
   endfunction
   function automatic logic [15:0] next_day(logic [7:0] y, logic [7:0] m, logic [7:0] dt);
      int mi, len;
      mi = b2i(m);
      len = (mi == 2) ? ((b2i(y) % 4 == 0) ? 29 : 28) :
            (mi == 4 || mi == 6 || mi == 9 || mi == 11) ? 30 : 31;
      if (b2i(dt) < len) return {m, i2b(b2i(dt) + 1)};
      return {i2b(mi % 12 + 1), 8'h01};
   endfunction
   // Set a time one second before midnight or noon and let it roll
   task automatic roll(input logic [7:0] y, m, dt, h, eh, input logic nd);
      logic [15:0] e;
      logic [7:0] v[6];
      e = nd ? next_day(y, m, dt) : {m, dt};
      v = '{y, m, dt, h, 8'h59, 8'h59};
      for (int i = 0; i < 6; i++) wr(8'(5 - i), v[i]);
      edges(55);
      rdc(8'h03, e[7:0]);
      rdc(8'h04, e[15:8]);
      rdc(8'h05, y);
      rdc(8'h02, eh);
      $display("Test roll %h/%h/%h done", y, m, dt);
   endtask
   // ----
   // Tests
   // ----
   initial begin
      rst = 1'b1;
      n = $urandom(32'h0000_1edb);
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rdc(8'h08, 8'h01);
      rdc(8'h0C, 8'h01);
      rdc(8'h13, 8'h00);
      rdc(8'h20, 8'h01);
      rdc(8'h03, 8'h01);
      wr(8'h00, 8'h30);
      edges(12);
      rdc(8'h00, 8'h00);
      rdc(8'h07, 8'h00);
      host.xfer(1'b0, 8'h09, 8'h00, rsp);
      chk(rsp, 33'h1_0000_0000);
      $display("Test reset done");
      wr(8'h0C, 8'h41);
      wr(8'h00, 8'h00);
      edges(12);
      rdc(8'h07, 8'h02);
      wr(8'h07, 8'h05);
      rdc(8'h07, 8'h00);
      $display("Test count done");
      for (int i = 0; i < 8; i++) begin
         a = 8'h80 | 8'($urandom_range(127));
         d = 8'($urandom);
         wr(a, d);
         rdc(a, d);
      end
      $display("Test sram done");
      roll(8'h24, 8'h02, 8'h28, 8'hA3, 8'h80, 1'b1);
      roll(8'h23, 8'h02, 8'h28, 8'hA3, 8'h80, 1'b1);
      roll(8'h24, 8'h04, 8'h30, 8'hA3, 8'h80, 1'b1);
      roll(8'h24, 8'h01, 8'h31, 8'hA3, 8'h80, 1'b1);
      roll(8'h96, 8'h02, 8'h28, 8'hA3, 8'h80, 1'b1);
      for (int i = 0; i < 2; i++) roll(i2b($urandom_range(99)), 8'h02, 8'h28, 8'hA3,
                                       8'h80, 1'b1);
      roll(8'h24, 8'h05, 8'h10, 8'h11, 8'h32, 1'b0);
      wr(8'h1D, 8'h82);
      wr(8'h1E, 8'h05);
      wr(8'h23, 8'h82);
      wr(8'h08, 8'h00);
      wr(8'h00, 8'h00);
      wait_irq(1'b0);
      chk(33'(n >= 1985 && n <= 2035), 33'h1);
      rdc(8'h08, 8'h30);
      chk({32'h0, irq_line}, 33'h0);
      wr(8'h08, 8'h00);
      repeat (3) @(posedge clk);
      chk({32'h0, irq_line}, 33'h1);
      rdc(8'h08, 8'h00);
      $display("Test single alarm done");
      wr(8'h0C, 8'hC1);
      wr(8'h00, 8'h01);
      wait_irq(1'b0);
      rdc(8'h08, 8'h30);
      rdc(8'h08, 8'h00);
      $display("Test auto clear done");
      wr(8'h0C, 8'h61);
      for (int k = 0; k < 2; k++) begin
         wr(8'h08, 8'h00);
         wr(8'h00, 8'h01);
         wait_irq(1'b0);
         chk(33'(n < 1100), 33'h1);
         wait_irq(1'b1);
         chk(33'(n >= PULSE && n <= PULSE + 3), 33'h1);
         rdc(8'h08, 8'h30);
      end
      $display("Test pulsed alarm done");
      wr(8'h13, 8'h80);
      rdc(8'h13, 8'h80);
      wr(8'h00, 8'h00);
      edges(15);
      rdc(8'h07, 8'h02);
      $display("Test 60 Hz done");
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(8'h08, 8'h01);
      rdc(8'h0C, 8'h01);
      edges(12);
      rdc(8'h07, 8'h00);
      $display("Test second reset done");
      tally_and_finish();
   end
   initial begin
      repeat (50000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end
endmodule
